/* background_debug_unit.sv */
`timescale 1ns/1ps
// What this block does
// - Debug clock picked by source select bit
// - Host falling edge starts bit, 0-1 cycles
// - Sample host bit ten cycles after start
// - Never drive line during host bits
// - Host actively drives highs when sending
// - Host holds line low two cycles minimum
// - Logic one: speedup pulse at cycle seven
// - Host releases before the speedup pulse
// - Host samples returned level near cycle ten
// - Host times bits in target clock cycles
// - Timeout abandons transaction, sequencer back to idle
module background_debug_unit
	import dbg_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        debug_clock_source_select_i,
	input  wire logic        alt_tick_i,
	input  wire logic        tx_mode_i,
	input  wire logic        tx_bit_i,
	input  wire logic        timeout_i,
	output logic             rx_bit_o,
	output logic             rx_valid_o,
	output logic             tx_done_o,
	output logic             busy_o,
	debug_line_if.device     link
);
	bit_state_t             state_r;
	bit_state_t             state_nxt;
	logic [CNT_W-1:0]       cnt_r;
	logic [CNT_W-1:0]       cnt_nxt;
	logic                   line_s_r;
	logic                   dir_tx_r;
	logic                   bit_val_r;
	logic                   tick;
	logic                   fall;
	logic                   in_bit;
	logic                   bit_end;
	logic                   rx_take;
	logic                   tx_take;
	logic                   drive_ok;
	logic                   dev_o_r;
	logic                   dev_oe_r;

	// Timing constants are five bits wide
	if (CNT_W != 5) begin
		$error("cell counter width must match the timing constants");
	end

	// Counter sits on one cell cycle
	function automatic logic at_cycle(
		input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] pos
	);
		return cnt == pos;
	endfunction

	// Counter lies in [lo, hi)
	function automatic logic in_span(
		input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] lo,
		input logic [CNT_W-1:0] hi
	);
		return (cnt >= lo) && (cnt < hi);
	endfunction

	assign tick     = (debug_clock_source_select_i == SRC_ALT) ? alt_tick_i : 1'b1;
	assign fall     = line_s_r & ~link.debug_line;
	assign in_bit   = (state_r == ST_BIT);
	assign bit_end  = at_cycle(cnt_r, BIT_CYC - 5'h01);

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			line_s_r <= LINE_IDLE;
		end else if (tick) begin
			line_s_r <= link.debug_line;
		end
	end

	// Bit-cell sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			ST_IDLE: begin
				if (fall) begin
					state_nxt = ST_BIT;
					cnt_nxt   = '0;
				end
			end
			ST_BIT: begin
				if (bit_end) begin
					state_nxt = ST_IDLE;
					cnt_nxt   = '0;
				end else begin
					cnt_nxt = cnt_r + 5'h01;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt   = '0;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || timeout_i) begin
			state_r <= ST_IDLE;
		end else if (tick) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || timeout_i) begin
			cnt_r <= '0;
		end else if (tick) begin
			cnt_r <= cnt_nxt;
		end
	end

	// Direction and return value, held for the cell
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			dir_tx_r  <= 1'b0;
			bit_val_r <= 1'b0;
		end else if (tick && !timeout_i && !in_bit && fall) begin
			dir_tx_r  <= tx_mode_i;
			bit_val_r <= tx_bit_i;
		end
	end

	assign rx_take  = tick && !timeout_i && in_bit
		&& !dir_tx_r && at_cycle(cnt_r, SAMPLE_CYC);
	assign tx_take  = tick && !timeout_i && in_bit
		&& dir_tx_r && bit_end;
	assign drive_ok = in_bit && dir_tx_r && !timeout_i;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			rx_bit_o <= 1'b0;
		end else if (rx_take) begin
			rx_bit_o <= line_s_r;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			rx_valid_o <= 1'b0;
		end else begin
			rx_valid_o <= rx_take;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			tx_done_o <= 1'b0;
		end else begin
			tx_done_o <= tx_take;
		end
	end

	// Busy drops at once on timeout
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= in_bit && !timeout_i;
		end
	end

	// Drive level follows the returned bit
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || !drive_ok) begin
			dev_o_r <= LINE_IDLE;
		end else if (tick) begin
			dev_o_r <= bit_val_r;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || !drive_ok) begin
			dev_oe_r <= 1'b0;
		end else if (tick) begin
			if (bit_val_r) begin
				dev_oe_r <= at_cycle(cnt_r, SPEEDUP_CYC - 5'h01);
			end else begin
				dev_oe_r <= in_span(cnt_r, ZERO_LOW_FROM - 5'h01, ZERO_LOW_UNTIL - 5'h01);
			end
		end
	end

	assign link.dev_line_o  = dev_o_r;
	assign link.dev_line_oe = dev_oe_r;
endmodule

/* dbg_pkg.sv */
package dbg_pkg;
	// Bit-cell timing, in target debug clock cycles
	localparam int unsigned CNT_W          = 5;
	localparam logic [4:0]  SPEEDUP_CYC    = 5'h07;
	localparam logic [4:0]  SAMPLE_CYC     = 5'h0a;
	localparam logic [4:0]  BIT_CYC        = 5'h10;
	localparam logic [4:0]  ZERO_LOW_FROM  = 5'h02;
	localparam logic [4:0]  ZERO_LOW_UNTIL = 5'h0d;
	localparam logic [4:0]  HOST_ONE_LOW   = 5'h04;
	localparam logic [4:0]  HOST_ZERO_LOW  = 5'h0d;
	localparam logic [4:0]  HOST_REQ_LOW   = 5'h04;
	// Clock-source select encoding
	localparam logic        SRC_BUS        = 1'b0;
	localparam logic        SRC_ALT        = 1'b1;
	// Idle level from the pullup
	localparam logic        LINE_IDLE      = 1'b1;
	// Clock period of mclk_i
	localparam int unsigned MCLK_PERIOD_NS = 50;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BIT  = 1'b1
	} bit_state_t;
endpackage

/* debug_line_if.sv */
`timescale 1ns/1ps
interface debug_line_if;
	logic host_line_o;
	logic host_line_oe;
	logic dev_line_o;
	logic dev_line_oe;
	logic debug_line;

	// Pseudo open-drain wire: any low drive wins, else driven high, else pullup
	assign debug_line = ((host_line_oe & ~host_line_o) | (dev_line_oe & ~dev_line_o)) ? 1'b0
		: dbg_pkg::LINE_IDLE;

	modport host (
		output host_line_o,
		output host_line_oe,
		input  debug_line
	);
	modport device (
		output dev_line_o,
		output dev_line_oe,
		input  debug_line
	);
endinterface

/* debug_host_pod.sv */
`timescale 1ns/1ps
module debug_host_pod
	import dbg_pkg::*;
#(
	parameter int unsigned TGT_DIV = 1
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        start_i,
	input  wire logic        read_i,
	input  wire logic        wr_bit_i,
	output logic             rd_bit_o,
	output logic             done_o,
	output logic             busy_o,
	debug_line_if.host       link
);
	if (TGT_DIV < 1 || TGT_DIV > 65535) begin
		$error("TGT_DIV out of range");
	end

	bit_state_t             state_r;
	logic [15:0]            div_r;
	logic [CNT_W-1:0]       tcnt_r;
	logic                   read_r;
	logic                   wbit_r;
	logic                   host_o_r;
	logic                   host_oe_r;
	logic                   tstep;
	logic [CNT_W-1:0]       low_len;

	assign tstep   = (div_r == 16'(TGT_DIV - 1));
	assign low_len = read_r ? HOST_REQ_LOW : (wbit_r ? HOST_ONE_LOW : HOST_ZERO_LOW);

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_r  <= ST_IDLE;
			div_r    <= '0;
			tcnt_r   <= '0;
			read_r   <= 1'b0;
			wbit_r   <= 1'b0;
			rd_bit_o <= 1'b0;
			done_o   <= 1'b0;
			busy_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start_i) begin
						state_r <= ST_BIT;
						busy_o  <= 1'b1;
						div_r   <= '0;
						tcnt_r  <= '0;
						read_r  <= read_i;
						wbit_r  <= wr_bit_i;
					end
				end
				ST_BIT: begin
					div_r <= tstep ? '0 : div_r + 16'h0001;
					if (tstep) begin
						if (read_r && tcnt_r == SAMPLE_CYC) begin
							rd_bit_o <= link.debug_line;
						end
						if (tcnt_r == BIT_CYC - 5'h01) begin
							state_r <= ST_IDLE;
							busy_o  <= 1'b0;
							done_o  <= 1'b1;
						end else begin
							tcnt_r <= tcnt_r + 5'h01;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
					busy_o  <= 1'b0;
				end
			endcase
		end
	end

	// Line drive
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			host_o_r  <= LINE_IDLE;
			host_oe_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			host_o_r  <= start_i ? 1'b0 : LINE_IDLE;
			host_oe_r <= start_i;
		end else if (tcnt_r < low_len) begin
			// hold low at least two cycles
			host_o_r  <= 1'b0;
			host_oe_r <= 1'b1;
		end else if (!read_r && tcnt_r < BIT_CYC - 5'h01) begin
			host_o_r  <= 1'b1;
			host_oe_r <= 1'b1;
		end else begin
			host_o_r  <= LINE_IDLE;
			host_oe_r <= 1'b0;
		end
	end

	assign link.host_line_o  = host_o_r;
	assign link.host_line_oe = host_oe_r;
endmodule

/* dbg_sva.sv */
`timescale 1ns/1ps
module dbg_sva (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic host_line_o,
	input wire logic host_line_oe,
	input wire logic dev_line_o,
	input wire logic dev_line_oe,
	input wire logic debug_line
);
	logic [4:0] fall_r;
	logic       dev_seen_r;
	wire        spd  = dev_line_oe & dev_line_o;
	wire        pull = dev_line_oe & ~dev_line_o;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// Cycles since line fell
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || $fell(debug_line))
			fall_r <= 5'h00;
		else if (fall_r != 5'h1f)
			fall_r <= fall_r + 5'h01;
	end
	// Device drive seen since line fell
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || $fell(debug_line))
			dev_seen_r <= 1'b0;
		else if (dev_line_oe)
			dev_seen_r <= 1'b1;
	end
	a_dev_quiet: assert property ((host_line_oe && host_line_o) |-> (!dev_line_oe && !dev_seen_r))
		else $error("device drove during host drive");
	a_host_low: assert property ($rose(host_line_oe) |-> (!host_line_o) [*2])
		else $error("host low too short");
	a_spd_one: assert property ($rose(spd) |=> !spd)
		else $error("speedup too long");
	a_spd_time: assert property ($rose(spd) |-> fall_r inside {[6:12]})
		else $error("speedup mistimed");
	a_host_clear: assert property (spd |-> !host_line_oe)
		else $error("host held line at speedup");
	a_pull_time: assert property ($rose(pull) |-> fall_r inside {[2:8]})
		else $error("zero drive mistimed");
	a_dev_bound: assert property ($rose(dev_line_oe) |-> ##[1:14] !dev_line_oe)
		else $error("device drive not released");
	a_host_len: assert property ($rose(host_line_oe) |-> ##[3:16] !host_line_oe)
		else $error("host bit too long");
	c_spd: cover property ($rose(spd));
	c_pull: cover property ($rose(pull));
	c_high: cover property (host_line_oe && host_line_o);
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import dbg_pkg::*;
	logic mclk_i  = 1'b0;
	logic rst_b_i = 1'b0;
	logic src     = SRC_BUS;
	logic tick    = 1'b1;
	logic tx_mode = 1'b0;
	logic tx_bit  = 1'b0;
	logic tmo     = 1'b0;
	logic start   = 1'b0;
	logic rd      = 1'b0;
	logic wr      = 1'b0;
	logic rx_bit, rx_valid, tx_done, dev_busy, rd_bit, done, last_rx, host_busy;
	int   err_count = 0;
	int   checked   = 0;
	int   cyc       = 0;
	int   n_rx      = 0;
	int   n_tx      = 0;
	debug_line_if lnk ();
	always #25 mclk_i = ~mclk_i;
	background_debug_unit background_debug_unit_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.debug_clock_source_select_i(src), .alt_tick_i(tick), .tx_mode_i(tx_mode),
		.tx_bit_i(tx_bit), .timeout_i(tmo), .rx_bit_o(rx_bit), .rx_valid_o(rx_valid),
		.tx_done_o(tx_done), .busy_o(dev_busy), .link(lnk.device));
	debug_host_pod debug_host_pod_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .start_i(start),
		.read_i(rd), .wr_bit_i(wr), .rd_bit_o(rd_bit), .done_o(done), .busy_o(host_busy),
		.link(lnk.host));
	dbg_sva dbg_sva_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .host_line_o(lnk.host_line_o),
		.host_line_oe(lnk.host_line_oe), .dev_line_o(lnk.dev_line_o),
		.dev_line_oe(lnk.dev_line_oe), .debug_line(lnk.debug_line));
	task automatic summarize();
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (rx_valid === 1'b1) begin
			n_rx    <= n_rx + 1;
			last_rx <= rx_bit;
		end
		if (tx_done === 1'b1)
			n_tx <= n_tx + 1;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One bit; k is the wait count that pulses timeout
	task automatic xfer(input logic r, w, s, t, input int k);
		int n;
		@(posedge mclk_i);
		rd      <= r;
		wr      <= w;
		tx_mode <= r;
		tx_bit  <= w;
		src     <= s;
		tick    <= t;
		start   <= 1'b1;
		@(posedge mclk_i);
		start <= 1'b0;
		#1;
		cmp(host_busy, 1'b1);
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(posedge mclk_i);
			tmo <= (n == k);
			n++;
			#1;
		end
		cmp(done, 1'b1);
		repeat (8) @(posedge mclk_i);
		tmo <= 1'b0;
		#1;
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			xfer(i[1], i[0], SRC_BUS, 1'b0, -1);
			if (i[1])
				cmp(rd_bit, i[0]);
			else
				cmp(last_rx, i[0]);
		end
		cmp(n_rx, 2);
		cmp(n_tx, 2);
		$display("test bus clock done");
		xfer(1'b0, 1'b1, SRC_ALT, 1'b0, 12);
		cmp(n_rx, 2);
		xfer(1'b0, 1'b1, SRC_ALT, 1'b1, -1);
		cmp(n_rx, 3);
		cmp(last_rx, 1);
		$display("test alt clock done");
		xfer(1'b1, 1'b0, SRC_BUS, 1'b1, 8);
		cmp(n_tx, 2);
		cmp(dev_busy, 0);
		xfer(1'b0, 1'b0, SRC_BUS, 1'b1, -1);
		cmp(last_rx, 0);
		$display("test timeout done");
		summarize();
	end
endmodule
